// File: sync_receive_hunt_standby.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// three-stage pin synchroniser; a new level counts once stages two and three agree
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// raw pins and filtered levels
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, level_next;

	// stage one is read only by stage two
	assign level_next = (s2_reg & s3_reg) | (level_o & (s2_reg | s3_reg));

	// shift chain plus filtered level
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_o <= '0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_o <= level_next;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (R1) host's first command: hunt, clear, enable
// (R2) entering hunt fills receive buffer with ones
// (R3) each receive edge shifts and compares
// (R4) match without parity ends hunt, sets sync
// (R5) with parity, sync at parity bit, unchecked
// (R6) characters start after the sync bit
// (R7) external pin high one period ends hunt
// (R8) later external pulses set sync again
// (R9) enter-hunt command restarts hunt any time; the code ignores it in standby
// (R10) synced characters matching sync set flag
// (R11) overrun and parity errors set flags only
// (R12) no parity check during hunt
// (R13) remote transmit clock matches receive clock
// (R14) only low character-length bits compared
// (R15) standby ignores clock edges internally
// (R16) reset pin falling edge enters standby
// (R17) software reset command enters standby
// (R18) only a mode write leaves standby
// (R19) standby drives fixed output pin levels
// (R20) host avoids data writes in standby
// (R21) host writes three zero controls first
// (R22) control byte 40h is software reset
// (R23) sync/break pin follows internal sync flag; the code holds it low in external-sync mode
module sync_receive_hunt_standby (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [4:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// serial link and device pins
	input wire logic SERIAL_IN_I,
	input wire logic RECEIVE_CLOCK_I,
	input wire logic EXT_SYNC_I,
	input wire logic RESET_PIN_I,
	// status and modem pins
	output logic SYNC_BREAK_OUT_O,
	output logic TRANSMIT_READY_OUT_O,
	output logic TRANSMITTER_EMPTY_OUT_O,
	output logic RECEIVE_READY_OUT_O,
	output logic SERIAL_OUT_O,
	output logic TERMINAL_READY_OUT_N_O,
	output logic REQUEST_TO_SEND_N_O
);
	logic rst_meta_reg, rst_n;
	logic [3:0] pins_level;
	logic sin, receive_clock_lvl, ext_lvl, rpin_lvl, receive_clock_prev_reg, rpin_prev_reg, ack_reg;
	logic [31:0] dat_reg;
	sync_rx_pkg::mode_t mode_reg;
	logic [7:0] sync_reg, cmd_reg, buf_reg, data_reg;
	logic standby_reg, rx_on_reg, hunt_reg, pend_reg, par_phase_reg;
	logic [2:0] cnt_reg;
	logic [1:0] ext_cnt_reg;
	logic receive_ready_out_reg, perr_reg, ovr_reg, syncf_reg;

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// all outside pins share one synchroniser bank
	pin_sync #(.WIDTH(4)) u_pins (
		.clk_i(CORE_CLK_I),
		.rst_n_i(rst_n),
		.pin_i({RESET_PIN_I, EXT_SYNC_I, RECEIVE_CLOCK_I, SERIAL_IN_I}),
		.level_o(pins_level)
	);
	assign sin = pins_level[0];
	assign receive_clock_lvl = pins_level[1];
	assign ext_lvl = pins_level[2];
	assign rpin_lvl = pins_level[3];

	// edge history of the filtered clock and reset pin
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			receive_clock_prev_reg <= 1'b0;
			rpin_prev_reg <= 1'b0;
		end else begin
			receive_clock_prev_reg <= receive_clock_lvl;
			rpin_prev_reg <= rpin_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus decode; ack once per request, dropped the cycle after; writes land at the ack edge
	logic req, wr, rd, wr_mode, wr_sync, wr_cmd, rd_status, rd_data;
	assign req = WB_CYC_I & WB_STB_I & ~ack_reg;
	assign wr = WB_CYC_I & WB_STB_I & ack_reg & WB_WE_I & WB_SEL_I[0];
	assign rd = req & ~WB_WE_I;
	assign wr_mode = wr & (WB_ADR_I == sync_rx_pkg::ADDR_MODE);
	assign wr_sync = wr & (WB_ADR_I == sync_rx_pkg::ADDR_SYNC);
	assign wr_cmd = wr & (WB_ADR_I == sync_rx_pkg::ADDR_CMD);
	assign rd_status = rd & (WB_ADR_I == sync_rx_pkg::ADDR_STATUS);
	assign rd_data = rd & (WB_ADR_I == sync_rx_pkg::ADDR_DATA);

	// standby control
	logic rpin_fall, soft_reset, enter_sb, eh_cmd;
	assign rpin_fall = rpin_prev_reg & ~rpin_lvl; // (R16)
	assign soft_reset = wr_cmd & (WB_DAT_I[7:0] == sync_rx_pkg::CMD_SOFT_RESET); // (R17) (R22)
	assign enter_sb = ~wr_mode & (rpin_fall | soft_reset);
	// commands are ignored while the clocks are blocked
	assign eh_cmd = wr_cmd & ~standby_reg & ~soft_reset & WB_DAT_I[sync_rx_pkg::CMD_EH]; // (R9)

	////////////////////////////////////////////////////////////////////////////////
	// receive datapath: new bit enters at the top of the character field
	logic rx_act, match, hunt_step, hunt_done, char_step, char_last, char_done, char_sync, par_expect, ext_event;
	logic [7:0] ins_mask, cmp_mask, shifted, char_val;
	assign rx_act = receive_clock_lvl & ~receive_clock_prev_reg & ~standby_reg & cmd_reg[sync_rx_pkg::CMD_RECEIVE_ENABLE_BIT]; // (R15)
	assign ins_mask = 8'h10 << mode_reg.len;
	assign cmp_mask = 8'hFF >> (2'h3 - mode_reg.len); // (R14)
	assign shifted = ({1'b1, buf_reg[7:1]} & ~ins_mask) | (sin ? ins_mask : 8'h00); // (R3)
	assign match = ((shifted ^ sync_reg) & cmp_mask) == 8'h00; // (R3) (R14)
	assign hunt_step = rx_act & rx_on_reg & hunt_reg & ~mode_reg.ext_sync;
	// the bit after a parity-mode match is the parity bit and is never checked
	assign hunt_done = (hunt_step & (pend_reg | (match & ~mode_reg.par_en))) | (ext_event & hunt_reg); // (R4) (R5) (R12)
	assign char_step = rx_act & rx_on_reg & ~hunt_reg;
	assign char_last = ~par_phase_reg & (cnt_reg == {1'b1, mode_reg.len});
	assign char_done = char_step & (par_phase_reg | (char_last & ~mode_reg.par_en));
	assign char_val = (par_phase_reg ? buf_reg : shifted) & cmp_mask;
	assign char_sync = char_done & (((char_val ^ sync_reg) & cmp_mask) == 8'h00); // (R10) (R14)
	assign par_expect = (^char_val) ^ ~mode_reg.par_even;

	// external sync: counts receive edges while the pin stays high
	assign ext_event = rx_act & rx_on_reg & mode_reg.ext_sync & ext_lvl
		& (ext_cnt_reg == (sync_rx_pkg::EXT_HIGH_EDGES - 2'h1)); // (R7) (R8)

	// sticky flags; hardware set wins over the clearing access
	logic receive_ready_out_next, perr_next, ovr_next, syncf_next, error_clear_bit;
	assign error_clear_bit = wr_cmd & ~standby_reg & WB_DAT_I[sync_rx_pkg::CMD_ECL];
	assign receive_ready_out_next = char_done | (receive_ready_out_reg & ~rd_data);
	assign perr_next = (char_done & par_phase_reg & (sin != par_expect)) | (perr_reg & ~error_clear_bit); // (R11)
	assign ovr_next = (char_done & receive_ready_out_reg & ~rd_data) | (ovr_reg & ~error_clear_bit); // (R11)
	assign syncf_next = hunt_done | char_sync | ext_event | (syncf_reg & ~rd_status); // (R7) (R10)

	////////////////////////////////////////////////////////////////////////////////
	// software-visible registers
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= sync_rx_pkg::MODE_RESET;
			sync_reg <= sync_rx_pkg::SYNC_RESET;
			cmd_reg <= sync_rx_pkg::CMD_RESET;
			standby_reg <= 1'b1;
		end else begin
			if (wr_mode) begin
				mode_reg <= sync_rx_pkg::mode_t'(WB_DAT_I[sync_rx_pkg::MODE_FIELD_MSB:sync_rx_pkg::MODE_FIELD_LSB]);
				standby_reg <= 1'b0; // (R18)
			end else if (enter_sb) begin
				standby_reg <= 1'b1; // (R16) (R17)
			end
			if (wr_sync) begin
				sync_reg <= WB_DAT_I[7:0];
			end
			if (enter_sb) begin
				cmd_reg <= sync_rx_pkg::CMD_RESET;
			end else if (wr_cmd & ~standby_reg) begin
				cmd_reg <= WB_DAT_I[7:0];
			end
		end
	end

	// hunt and character assembly
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			rx_on_reg <= 1'b0;
			hunt_reg <= 1'b0;
			pend_reg <= 1'b0;
			par_phase_reg <= 1'b0;
			cnt_reg <= 3'h0;
			buf_reg <= sync_rx_pkg::BUF_ALL_ONES;
			data_reg <= 8'h00;
		end else if (enter_sb | eh_cmd) begin
			rx_on_reg <= ~enter_sb; // (R9)
			hunt_reg <= ~enter_sb;
			pend_reg <= 1'b0;
			par_phase_reg <= 1'b0;
			cnt_reg <= 3'h0;
			buf_reg <= sync_rx_pkg::BUF_ALL_ONES; // (R2)
		end else if (hunt_done) begin
			hunt_reg <= 1'b0;
			pend_reg <= 1'b0;
			cnt_reg <= 3'h0; // (R6)
		end else if (hunt_step) begin
			buf_reg <= shifted;
			pend_reg <= match & mode_reg.par_en; // (R5)
		end else if (char_step & par_phase_reg) begin
			par_phase_reg <= 1'b0;
			data_reg <= char_val;
		end else if (char_step) begin
			buf_reg <= shifted;
			cnt_reg <= char_last ? 3'h0 : cnt_reg + 3'h1;
			par_phase_reg <= char_last & mode_reg.par_en;
			if (char_done) begin
				data_reg <= char_val;
			end
		end
	end

	// flags, external-pulse counter
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			receive_ready_out_reg <= 1'b0;
			perr_reg <= 1'b0;
			ovr_reg <= 1'b0;
			syncf_reg <= 1'b0;
			ext_cnt_reg <= 2'h0;
		end else if (enter_sb | standby_reg) begin
			receive_ready_out_reg <= 1'b0;
			perr_reg <= 1'b0;
			ovr_reg <= 1'b0;
			syncf_reg <= 1'b0;
			ext_cnt_reg <= 2'h0;
		end else begin
			receive_ready_out_reg <= receive_ready_out_next;
			perr_reg <= perr_next;
			ovr_reg <= ovr_next;
			syncf_reg <= syncf_next;
			if (!ext_lvl) begin
				ext_cnt_reg <= 2'h0; // (R8)
			end else if (rx_act & (ext_cnt_reg != sync_rx_pkg::EXT_HIGH_EDGES)) begin
				ext_cnt_reg <= ext_cnt_reg + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data selection; unmapped addresses read zero
	logic [31:0] status_word, rd_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[sync_rx_pkg::ST_TRANSMIT_READY_OUT] = ~standby_reg & cmd_reg[sync_rx_pkg::CMD_TXEN];
		status_word[sync_rx_pkg::ST_RECEIVE_READY_OUT] = receive_ready_out_reg;
		status_word[sync_rx_pkg::ST_TRANSMITTER_EMPTY_OUT] = ~standby_reg;
		status_word[sync_rx_pkg::ST_PERR] = perr_reg;
		status_word[sync_rx_pkg::ST_OVR] = ovr_reg;
		status_word[sync_rx_pkg::ST_SYNC] = syncf_reg;
		status_word[sync_rx_pkg::ST_STANDBY] = standby_reg;
		status_word[sync_rx_pkg::ST_HUNT] = hunt_reg;
	end
	assign rd_word = (WB_ADR_I == sync_rx_pkg::ADDR_MODE) ? {25'h0, mode_reg, 2'h0}
		: (WB_ADR_I == sync_rx_pkg::ADDR_SYNC) ? {24'h0, sync_reg}
		: (WB_ADR_I == sync_rx_pkg::ADDR_CMD) ? {24'h0, cmd_reg}
		: (WB_ADR_I == sync_rx_pkg::ADDR_STATUS) ? status_word
		: (WB_ADR_I == sync_rx_pkg::ADDR_DATA) ? {24'h0, data_reg}
		: 32'h0000_0000;

	// bus answer one cycle after the strobe
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			dat_reg <= rd ? rd_word : 32'h0000_0000;
		end
	end
	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = dat_reg;

	////////////////////////////////////////////////////////////////////////////////
	// pin outputs, registered; modem pins are active low so high means idle
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			SYNC_BREAK_OUT_O <= 1'b0;
			TRANSMIT_READY_OUT_O <= 1'b0;
			TRANSMITTER_EMPTY_OUT_O <= 1'b0;
			RECEIVE_READY_OUT_O <= 1'b0;
			SERIAL_OUT_O <= 1'b1;
			TERMINAL_READY_OUT_N_O <= 1'b1;
			REQUEST_TO_SEND_N_O <= 1'b1;
		end else begin
			SYNC_BREAK_OUT_O <= ~standby_reg & ~mode_reg.ext_sync & syncf_reg; // (R23) (R19)
			TRANSMIT_READY_OUT_O <= ~standby_reg & cmd_reg[sync_rx_pkg::CMD_TXEN]; // (R19)
			TRANSMITTER_EMPTY_OUT_O <= ~standby_reg; // (R19)
			RECEIVE_READY_OUT_O <= ~standby_reg & receive_ready_out_reg; // (R19)
			SERIAL_OUT_O <= 1'b1; // (R19)
			TERMINAL_READY_OUT_N_O <= standby_reg | ~cmd_reg[sync_rx_pkg::CMD_TERM_READY]; // (R19)
			REQUEST_TO_SEND_N_O <= standby_reg | ~cmd_reg[sync_rx_pkg::CMD_RTS]; // (R19)
		end
	end
endmodule
`default_nettype wire

// File: sync_rx_pkg.sv
`default_nettype none
package sync_rx_pkg;
	// register byte addresses on the bus
	localparam logic [4:0] ADDR_MODE = 5'h00;
	localparam logic [4:0] ADDR_SYNC = 5'h04;
	localparam logic [4:0] ADDR_CMD = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0C;
	localparam logic [4:0] ADDR_DATA = 5'h10;
	// command byte bit positions
	localparam int CMD_TXEN = 0;
	localparam int CMD_TERM_READY = 1;
	localparam int CMD_RECEIVE_ENABLE_BIT = 2;
	localparam int CMD_ECL = 4;
	localparam int CMD_RTS = 5;
	localparam int CMD_EH = 7;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h40;
	// mode byte field positions
	localparam int MODE_FIELD_LSB = 2;
	localparam int MODE_FIELD_MSB = 6;
	// status word bit positions
	localparam int ST_TRANSMIT_READY_OUT = 0;
	localparam int ST_RECEIVE_READY_OUT = 1;
	localparam int ST_TRANSMITTER_EMPTY_OUT = 2;
	localparam int ST_PERR = 3;
	localparam int ST_OVR = 4;
	localparam int ST_SYNC = 6;
	localparam int ST_STANDBY = 8;
	localparam int ST_HUNT = 9;
	// reset values
	localparam logic [7:0] SYNC_RESET = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] BUF_ALL_ONES = 8'hFF;
	// receive-clock rising edges seen with the sync pin high before it counts
	localparam logic [1:0] EXT_HIGH_EDGES = 2'h2;
	// mode fields: external sync, even parity, parity enable, length code
	typedef struct packed {
		logic ext_sync;
		logic par_even;
		logic par_en;
		logic [1:0] len;
	} mode_t;
	localparam mode_t MODE_RESET = '{ext_sync: 1'b0, par_even: 1'b0, par_en: 1'b0, len: 2'h0};
endpackage
`default_nettype wire

// File: sync_rhs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the top ports only; standby is read back from the empty pin
module sync_rhs_chk (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// register bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [4:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// device pins
	input wire logic RESET_PIN_I,
	input wire logic SYNC_BREAK_OUT_O,
	input wire logic TRANSMIT_READY_OUT_O,
	input wire logic TRANSMITTER_EMPTY_OUT_O,
	input wire logic RECEIVE_READY_OUT_O,
	input wire logic SERIAL_OUT_O,
	input wire logic TERMINAL_READY_OUT_N_O,
	input wire logic REQUEST_TO_SEND_N_O
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	// bus decode; mode writes stay masked a while because the pins lag the flag
	wire logic take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire logic wr0 = take & WB_WE_I & WB_SEL_I[0];
	wire logic mode_wr = WB_CYC_I & WB_WE_I & (WB_ADR_I == sync_rx_pkg::ADDR_MODE);
	wire logic standby = ~TRANSMITTER_EMPTY_OUT_O;
	////////////////////////////////////////
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
	ack_latency_a: assert property (take |=> WB_ACK_O) else $error("ack not one cycle after request");
	idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data outside ack");
	serial_high_a:
		assert property (SERIAL_OUT_O) else $error("serial output not idle high");
	standby_pins_a:
		assert property (standby |-> !TRANSMIT_READY_OUT_O && !RECEIVE_READY_OUT_O && !SYNC_BREAK_OUT_O
			&& TERMINAL_READY_OUT_N_O && REQUEST_TO_SEND_N_O) else $error("wrong pin level in standby");
	pin_entry_a:
		assert property ($fell(RESET_PIN_I) |-> ##[1:10] standby) else $error("reset pin fall missed");
	mode_exit_a:
		assert property (wr0 && WB_ADR_I == sync_rx_pkg::ADDR_MODE |-> ##[1:4] !standby)
		else $error("mode write kept standby");
	soft_reset_a:
		assert property (wr0 && WB_ADR_I == sync_rx_pkg::ADDR_CMD && WB_DAT_I[7:0] == sync_rx_pkg::CMD_SOFT_RESET
			|-> ##[1:4] standby) else $error("soft reset missed");
	standby_hold_a:
		assert property (standby && !(mode_wr || $past(mode_wr) || $past(mode_wr, 2)) |=> standby)
		else $error("standby left without mode write");
	status_standby_a:
		assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == sync_rx_pkg::ADDR_STATUS
			|-> WB_DAT_O[sync_rx_pkg::ST_STANDBY] == standby) else $error("status standby bit wrong");
endmodule
bind sync_receive_hunt_standby sync_rhs_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RESET_PIN_I(RESET_PIN_I),
	.SYNC_BREAK_OUT_O(SYNC_BREAK_OUT_O), .TRANSMIT_READY_OUT_O(TRANSMIT_READY_OUT_O),
	.TRANSMITTER_EMPTY_OUT_O(TRANSMITTER_EMPTY_OUT_O), .RECEIVE_READY_OUT_O(RECEIVE_READY_OUT_O),
	.SERIAL_OUT_O(SERIAL_OUT_O), .TERMINAL_READY_OUT_N_O(TERMINAL_READY_OUT_N_O),
	.REQUEST_TO_SEND_N_O(REQUEST_TO_SEND_N_O));
`default_nettype wire

// File: serial_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// remote synchronous sender; its clock stands still between frames
module serial_tx_model (
	// serial link toward the receiver
	output logic clk_o,
	output logic data_o
);
	localparam realtime HALF = 62.5;
	initial begin
		clk_o = 1'b0;
		data_o = 1'b0;
	end
	// lsb first, data set half a period ahead of each rising edge
	task automatic send(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			data_o = v[i];
			#HALF clk_o = 1'b1;
			#HALF clk_o = 1'b0;
		end
		// released line shows the inverse, never a stale level
		data_o = ~data_o;
	endtask
endmodule
`default_nettype wire

// File: sync_receive_hunt_standby_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_receive_hunt_standby_tb;
	localparam logic [4:0] a_mode = sync_rx_pkg::ADDR_MODE;
	localparam logic [4:0] a_sync = sync_rx_pkg::ADDR_SYNC;
	localparam logic [4:0] a_cmd = sync_rx_pkg::ADDR_CMD;
	localparam logic [4:0] a_stat = sync_rx_pkg::ADDR_STATUS;
	localparam logic [4:0] a_data = sync_rx_pkg::ADDR_DATA;
	logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ext = 1'b0, rpin = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	wire logic [31:0] rdat;
	wire logic ack, sbrk, transmit_ready_out, transmitter_empty_out, receive_ready_out, sout, dtr_n, rts_n, rclk, sdat;
	logic [63:0] notes[$];
	logic [63:0] note;
	logic [7:0] ch;
	int n_mismatch = 0;
	int n_tests = 0;
	sync_receive_hunt_standby u_dut (.CORE_CLK_I(clk), .RESETN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.SERIAL_IN_I(sdat), .RECEIVE_CLOCK_I(rclk), .EXT_SYNC_I(ext), .RESET_PIN_I(rpin),
		.SYNC_BREAK_OUT_O(sbrk), .TRANSMIT_READY_OUT_O(transmit_ready_out), .TRANSMITTER_EMPTY_OUT_O(transmitter_empty_out),
		.RECEIVE_READY_OUT_O(receive_ready_out), .SERIAL_OUT_O(sout), .TERMINAL_READY_OUT_N_O(dtr_n),
		.REQUEST_TO_SEND_N_O(rts_n));
	serial_tx_model u_tx (.clk_o(rclk), .data_o(sdat));
	always #5 clk = ~clk;
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// one classic cycle; the note pairs expected read data with a mask (zero for writes)
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [31:0] e,
		input logic [31:0] m);
		int n;
		notes.push_back({e, m});
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40) begin
			n_mismatch++;
			end_of_test();
		end
	endtask
	// pins sampled well after the change; order transmit_ready_out transmitter_empty_out receive_ready_out sbrk sout dtr_n rts_n
	task automatic pins(input logic [6:0] e);
		repeat (10) @(posedge clk);
		#1 check({25'h0, transmit_ready_out, transmitter_empty_out, receive_ready_out, sbrk, sout, dtr_n, rts_n}, {25'h0, e});
	endtask
	task automatic pulse(input int n);
		@(posedge clk);
		ext <= 1'b1;
		u_tx.send(8'hFF, n);
		@(posedge clk);
		ext <= 1'b0;
	endtask
	// read data is compared against the oldest note when ack shows
	always @(posedge clk) begin
		if (ack === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			if (note[31:0] != 32'h0) check(rdat & note[31:0], note[63:32]);
		end
	end
	initial begin
		#150us;
		n_mismatch++;
		end_of_test();
	end
	////////////////////////////////////////
	initial begin
		void'($urandom(81896));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		pins(7'b0000111);
		acc(0, a_stat, 0, 32'h100, 32'h100);
		acc(0, a_sync, 0, 32'h0, 32'hFF);
		acc(1, a_cmd, 8'h22, 0, 0);
		acc(0, a_cmd, 0, 32'h0, 32'hFF);
		acc(0, 5'h14, 0, 32'h0, 32'hFFFFFFFF);
		// internal hunt, 8 bits, no parity
		acc(1, a_sync, 8'h16, 0, 0);
		acc(1, a_mode, 8'h0C, 0, 0);
		acc(0, a_mode, 0, 32'h0C, 32'hFF);
		@(posedge clk);
		sel <= 4'h0;
		acc(1, a_sync, 8'h55, 0, 0);
		sel <= 4'hF;
		acc(0, a_sync, 0, 32'h16, 32'hFF);
		acc(1, a_cmd, 8'hB7, 0, 0);
		acc(0, a_stat, 0, 32'h200, 32'h340);
		u_tx.send(8'h16, 8);
		pins(7'b1101100);
		acc(0, a_stat, 0, 32'h040, 32'h240);
		acc(0, a_stat, 0, 32'h0, 32'h040);
		ch = 8'($urandom);
		u_tx.send(ch, 8);
		acc(0, a_data, 0, {24'h0, ch}, 32'hFF);
		u_tx.send(8'h16, 8);
		acc(0, a_stat, 0, 32'h042, 32'h042);
		ch = 8'($urandom);
		u_tx.send(ch, 8);
		acc(0, a_stat, 0, 32'h012, 32'h01A);
		// re-hunt: one zero bit matches only if the buffer was refilled with ones
		acc(1, a_sync, 8'h7F, 0, 0);
		acc(1, a_cmd, 8'hB7, 0, 0);
		u_tx.send(8'h00, 1);
		acc(0, a_stat, 0, 32'h040, 32'h250);
		// five bits with odd parity, upper sync bits are junk
		acc(1, a_sync, 8'hEC, 0, 0);
		acc(1, a_mode, 8'h10, 0, 0);
		acc(1, a_cmd, 8'hB7, 0, 0);
		u_tx.send(8'h0C, 5);
		acc(0, a_stat, 0, 32'h200, 32'h240);
		u_tx.send(8'h00, 1);
		acc(0, a_stat, 0, 32'h040, 32'h248);
		u_tx.send(8'h03, 6);
		acc(0, a_stat, 0, 32'h00A, 32'h00A);
		acc(0, a_data, 0, 32'h03, 32'h1F);
		// external sync pin
		acc(1, a_mode, 8'h4C, 0, 0);
		acc(1, a_cmd, 8'hB7, 0, 0);
		pulse(1);
		u_tx.send(8'hFF, 1);
		acc(0, a_stat, 0, 32'h200, 32'h240);
		pulse(2);
		acc(0, a_stat, 0, 32'h040, 32'h240);
		pins(7'b1100100);
		acc(0, a_stat, 0, 32'h0, 32'h040);
		pulse(2);
		acc(0, a_stat, 0, 32'h040, 32'h040);
		// seven bits, even parity, top sync bit is junk
		acc(1, a_sync, 8'hBA, 0, 0);
		acc(1, a_mode, 8'h38, 0, 0);
		acc(1, a_cmd, 8'hB7, 0, 0);
		u_tx.send(8'h3A, 8);
		acc(0, a_stat, 0, 32'h040, 32'h248);
		u_tx.send(8'h05, 8);
		acc(0, a_stat, 0, 32'h002, 32'h05A);
		acc(0, a_data, 0, 32'h05, 32'h7F);
		// soft reset, clocks ignored meanwhile; three zero controls go first
		repeat (3) acc(1, a_cmd, 8'h00, 0, 0);
		acc(1, a_cmd, 8'h40, 0, 0);
		pins(7'b0000111);
		pulse(3);
		acc(0, a_stat, 0, 32'h100, 32'h142);
		acc(1, a_mode, 8'h0C, 0, 0);
		acc(0, a_stat, 0, 32'h0, 32'h100);
		// reset pin: standby only after the high level ends
		@(posedge clk);
		rpin <= 1'b1;
		acc(0, a_stat, 0, 32'h0, 32'h100);
		@(posedge clk);
		rpin <= 1'b0;
		pins(7'b0000111);
		end_of_test();
	end
endmodule
`default_nettype wire
